/* File: pkg/rtc_map.vh */
// rtc_map.vh: location indices, field positions, reset values and timing
// counts for the real-time clock core; definitions only.
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// location index; bus byte address is four times the index
`define RTC_IX_SEC       5'h00
`define RTC_IX_ALM_SEC   5'h01
`define RTC_IX_MIN       5'h02
`define RTC_IX_ALM_MIN   5'h03
`define RTC_IX_HOUR      5'h04
`define RTC_IX_ALM_HOUR  5'h05
`define RTC_IX_DOW       5'h06
`define RTC_IX_DATE      5'h07
`define RTC_IX_MON       5'h08
`define RTC_IX_YEAR      5'h09
`define RTC_IX_CRA       5'h0a
`define RTC_IX_CRB       5'h0b
`define RTC_IX_CRC       5'h0c
`define RTC_IX_CRD       5'h0d
`define RTC_IX_ALM_DOW   5'h0e
`define RTC_IX_ALM_DATE  5'h0f
`define RTC_IX_ALM_MON   5'h10
`define RTC_IX_ALM_YEAR  5'h11

// field positions
`define RTC_CRA_UIP      7
`define RTC_CRB_SET      7
`define RTC_CRB_PIE      6
`define RTC_CRB_AIE      5
`define RTC_CRB_UIE      4
`define RTC_CRB_DM       2
`define RTC_CRB_H24      1

// reset values
`define RTC_CRA_RST      8'h20
`define RTC_CRB_RST      8'h02
`define RTC_CRD_VAL      8'h80

// timing
`define RTC_REF_HZ       32768
`define RTC_DIV_BITS     15
`define RTC_DIV_HALF     15'h4000
`define RTC_UIP_US       244
`define RTC_UIP_TICKS    ((`RTC_UIP_US * `RTC_REF_HZ + 999999) / 1000000)
`define RTC_SYS_MHZ      200
`define RTC_LOCK_MS      100
`define RTC_LOCK_CYC     (`RTC_LOCK_MS * `RTC_SYS_MHZ * 1000)

`endif

/* File: rtl/rtc_field_inc.v */
// rtc_field_inc.v: one time field incrementer with wrap, bcd or binary.
// assumes lo/hi are binary bounds and the value is within them.
`timescale 1ns/10ps
module rtc_field_inc (
   input  wire       bcd_i,
   input  wire [7:0] val_i,
   input  wire [7:0] lo_i,
   input  wire [7:0] hi_i,
   output reg  [7:0] nxt_o,
   output reg        wrap_o
);
   reg [7:0] b;
   reg [7:0] t;
   reg [7:0] u;

   // decode, step, wrap to the low bound, encode back
   always @* begin
      b = bcd_i ? ({1'b0, val_i[7:4], 3'b000} + {3'b000, val_i[7:4], 1'b0}
                   + {4'h0, val_i[3:0]}) : val_i;
      wrap_o = (b >= hi_i);
      b      = wrap_o ? lo_i : b + 8'h01;
      t      = b / 8'h0a;
      u      = b % 8'h0a;
      nxt_o  = bcd_i ? {t[3:0], u[3:0]} : b;
   end
endmodule // rtc_field_inc

/* File: rtl/rtc_div.v */
// rtc_div.v: fifteen stage divider of the reference tick, with update,
// update-pending and periodic taps.
// assumes ref_tick_i is a one-cycle pulse per reference period.
`timescale 1ns/10ps
`include "rtc_map.vh"
module rtc_div #(
   parameter W = `RTC_DIV_BITS
) (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       ref_tick_i,
   input  wire       run_i,
   input  wire       start_i,
   input  wire [3:0] tap_i,
   output wire       uip_o,
   output reg        upd_o,
   output reg        per_o
);
   localparam integer UIP_N = `RTC_UIP_TICKS + 1;
   reg  [W-1:0] cnt;
   // offset cut to the counter width on purpose
   wire [W-1:0] sum  = cnt + UIP_N[W-1:0];
   wire [W-1:0] mask = ({{(W-1){1'b0}}, 1'b1} << tap_i) - 1'b1;
   wire [W-1:0] half = {{(W-1){1'b0}}, 1'b1} << (tap_i - 4'h1);

   // ripple of divide-by-two stages modelled as one counter
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= {W{1'b0}};
         upd_o <= 1'b0;
         per_o <= 1'b0;
      end else begin
         upd_o <= run_i & ref_tick_i & (&cnt);
         // periodic lands half a period plus uip window ahead of update
         per_o <= run_i & ref_tick_i & (tap_i != 4'h0) & ((sum & mask) == half);
         if (start_i)
            cnt <= `RTC_DIV_HALF;
         else if (run_i & ref_tick_i)
            cnt <= cnt + 1'b1;
      end
   end

   // pending flag covers the last ticks before the wrap
   assign uip_o = run_i & (cnt >= ({W{1'b1}} - `RTC_UIP_TICKS + 1));
endmodule // rtc_div

/* File: rtl/rtc_core.v */
// rtc_core.v: time keeping and alarm core with avalon-mm register slave.
// assumes SLOW_CLK_I and VCC_OK_I are synchronous to CLK_SYS_I and the
// reference is far slower than the system clock.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rtc_map.vh"
module rtc_core #(
   parameter LOCK_CYC = `RTC_LOCK_CYC
) (
   input  wire        CLK_SYS_I,
   input  wire        RST_N_I,
   input  wire        SLOW_CLK_I,
   input  wire        VCC_OK_I,
   input  wire [6:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   output reg  [31:0] AVS_READDATA_O,
   output wire        AVS_WAITREQUEST_O,
   output wire        RTC_IRQ_O,
   output reg         RTC_IRQ_OE_N_O
);
   reg         rst_s1;
   reg         rst_s2;
   wire        rst_n = rst_s2;
   reg         ref_d;
   wire        ref_tick;
   reg  [2:0]  divider_control;
   reg  [3:0]  rate_select;
   reg  [7:0]  control_reg_b;
   reg         periodic_flag;
   reg         alarm_flag;
   reg         update_end_flag;
   reg  [7:0]  cur [0:6];
   reg  [7:0]  usr [0:6];
   reg  [7:0]  alm [0:6];
   reg         load_pend;
   reg         alm_wait;
   reg         norm_d;
   reg         locked;
   reg  [31:0] lock_cnt;
   reg         ack;
   wire        normal;
   wire        update_pending;
   wire        upd;
   wire        per_ev;
   reg  [3:0]  tap;
   wire        frozen = control_reg_b[`RTC_CRB_SET];
   wire        bcd    = ~control_reg_b[`RTC_CRB_DM];
   wire        h24    = control_reg_b[`RTC_CRB_H24];
   wire        irq_flag_any;
   wire        req    = AVS_READ_I | AVS_WRITE_I;
   wire        fire   = req & ack & ~locked;
   wire        wr     = fire & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
   wire        clr_c;
   wire [7:0]  wdat   = AVS_WRITEDATA_I[7:0];
   wire [4:0]  ix     = AVS_ADDRESS_I[6:2];
   reg  [2:0]  slot;
   reg         is_time;
   reg         is_alm;
   reg  [7:0]  rd_val;
   reg  [7:0]  lo_w [0:6];
   reg  [7:0]  hi_w [0:6];
   reg  [7:0]  in_w [0:6];
   wire [7:0]  nx_w [0:6];
   wire [6:0]  wrap_w;
   reg  [7:0]  mdays;
   reg  [7:0]  mon_b;
   reg  [7:0]  yr_b;
   reg         hr_day;
   reg         alm_hit;
   integer     i;
   localparam [7:0] CRA_RST = `RTC_CRA_RST;

   // reset release through two flops, assertion stays asynchronous
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // rising edge of the reference gives one tick per 30.5 us
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n)
         ref_d <= 1'b0;
      else
         ref_d <= SLOW_CLK_I;
   end
   assign ref_tick = SLOW_CLK_I & ~ref_d;

   // 01x and 100 count; 11x, 101 and 00x all stop the chain, and a restart loads the half-second point
   assign normal = (divider_control == 3'h2) | (divider_control == 3'h3)
                 | (divider_control == 3'h4);

   // rate code to tap: codes 1 and 2 reuse taps 7 and 8, the taps of codes 8 and 9
   always @* begin
      case (rate_select)
         4'h0:    tap = 4'h0;
         4'h1:    tap = 4'h7;
         4'h2:    tap = 4'h8;
         default: tap = rate_select - 4'h1;
      endcase
   end

   rtc_div #(
      .W          (`RTC_DIV_BITS)
   ) u_div (
      .clk_i      (CLK_SYS_I),
      .rst_n_i    (rst_n),
      .ref_tick_i (ref_tick),
      .run_i      (normal),
      .start_i    (normal & ~norm_d),
      .tap_i      (tap),
      .uip_o      (update_pending),
      .upd_o      (upd),
      .per_o      (per_ev)
   );

   function [7:0] to_bin;
      input [7:0] v;
      input       b;
      begin
         to_bin = b ? ({1'b0, v[7:4], 3'b000} + {3'b000, v[7:4], 1'b0} + {4'h0, v[3:0]}) : v;
      end
   endfunction

   // field bounds; month length from month and year
   always @* begin
      mon_b = to_bin(cur[5], bcd);
      yr_b  = to_bin(cur[6], bcd);
      case (mon_b)
         8'h02:   mdays = (yr_b[1:0] == 2'b00) ? 8'h1d : 8'h1c;
         8'h04, 8'h06, 8'h09, 8'h0b: mdays = 8'h1e;
         default: mdays = 8'h1f;
      endcase
      for (i = 0; i < 7; i = i + 1) begin
         in_w[i] = cur[i];
         lo_w[i] = 8'h00;
         hi_w[i] = 8'h3b;
      end
      in_w[2] = h24 ? cur[2] : {1'b0, cur[2][6:0]};
      lo_w[2] = h24 ? 8'h00 : 8'h01;
      hi_w[2] = h24 ? 8'h17 : 8'h0c;
      lo_w[3] = 8'h01;
      hi_w[3] = 8'h07;
      lo_w[4] = 8'h01;
      hi_w[4] = mdays;
      lo_w[5] = 8'h01;
      hi_w[5] = 8'h0c;
      hi_w[6] = 8'h63;
      // 12 hour day rolls at eleven pm, not at the 12 to 1 wrap
      hr_day  = h24 ? wrap_w[2] : (cur[2][7] & (to_bin({1'b0, cur[2][6:0]}, bcd) == 8'h0b));
   end

   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_fld
         rtc_field_inc u_inc (
            .bcd_i  (bcd),
            .val_i  (in_w[g]),
            .lo_i   (lo_w[g]),
            .hi_i   (hi_w[g]),
            .nxt_o  (nx_w[g]),
            .wrap_o (wrap_w[g])
         );
      end
   endgenerate

   // address decode of the location index
   always @* begin
      slot    = 3'h0;
      is_time = 1'b0;
      is_alm  = 1'b0;
      if (ix == `RTC_IX_SEC) begin
         slot = 3'h0; is_time = 1'b1;
      end else if (ix == `RTC_IX_MIN) begin
         slot = 3'h1; is_time = 1'b1;
      end else if (ix == `RTC_IX_HOUR) begin
         slot = 3'h2; is_time = 1'b1;
      end else if (ix == `RTC_IX_DOW) begin
         slot = 3'h3; is_time = 1'b1;
      end else if (ix == `RTC_IX_DATE) begin
         slot = 3'h4; is_time = 1'b1;
      end else if (ix == `RTC_IX_MON) begin
         slot = 3'h5; is_time = 1'b1;
      end else if (ix == `RTC_IX_YEAR) begin
         slot = 3'h6; is_time = 1'b1;
      end else if (ix == `RTC_IX_ALM_SEC) begin
         slot = 3'h0; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_MIN) begin
         slot = 3'h1; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_HOUR) begin
         slot = 3'h2; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_DOW) begin
         slot = 3'h3; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_DATE) begin
         slot = 3'h4; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_MON) begin
         slot = 3'h5; is_alm = 1'b1;
      end else if (ix == `RTC_IX_ALM_YEAR) begin
         slot = 3'h6; is_alm = 1'b1;
      end
   end

   // read mux; frozen reads see the snapshot
   always @* begin
      if (is_time)
         rd_val = frozen ? usr[slot] : cur[slot];
      else if (is_alm)
         rd_val = alm[slot];
      else if (ix == `RTC_IX_CRA)
         rd_val = {update_pending, divider_control, rate_select};
      else if (ix == `RTC_IX_CRB)
         rd_val = control_reg_b;
      else if (ix == `RTC_IX_CRC)
         rd_val = {irq_flag_any, periodic_flag, alarm_flag, update_end_flag, 4'h0};
      else if (ix == `RTC_IX_CRD)
         rd_val = `RTC_CRD_VAL;
      else
         rd_val = 8'h00;
   end

   // alarm compare, don't-care fields match anything
   always @* begin
      alm_hit = 1'b1;
      for (i = 0; i < 7; i = i + 1)
         if (!((alm[i][7:6] == 2'b11) || (alm[i] == cur[i])))
            alm_hit = 1'b0;
   end

   // bus handshake: one wait cycle, data captured before the release
   assign AVS_WAITREQUEST_O = req & ~ack;
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         ack            <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         ack <= req & ~ack;
         if (AVS_READ_I & ~ack)
            AVS_READDATA_O <= {24'h00_0000, locked ? 8'h00 : rd_val};
      end
   end

   // power lockout; release LOCK_CYC cycles after supply returns, or at once while the divider counts
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         locked   <= 1'b1;
         lock_cnt <= 32'h0000_0000;
      end else if (!VCC_OK_I) begin
         locked   <= 1'b1;
         lock_cnt <= 32'h0000_0000;
      end else if (locked) begin
         if (normal || (lock_cnt >= LOCK_CYC - 1))
            locked <= 1'b0;
         else
            lock_cnt <= lock_cnt + 32'h0000_0001;
      end
   end

   // control registers and activation edge
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         divider_control <= CRA_RST[6:4];
         rate_select     <= CRA_RST[3:0];
         control_reg_b   <= `RTC_CRB_RST;
         norm_d          <= 1'b0;
      end else begin
         norm_d <= normal;
         if (wr && ix == `RTC_IX_CRA) begin
            divider_control <= wdat[6:4];
            rate_select     <= wdat[3:0];
         end
         if (wr && ix == `RTC_IX_CRB)
            control_reg_b <= wdat;
      end
   end

   // flags: reading c clears, a same-cycle event still sets
   assign clr_c = fire & AVS_READ_I & (ix == `RTC_IX_CRC);
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         periodic_flag   <= 1'b0;
         alarm_flag      <= 1'b0;
         update_end_flag <= 1'b0;
         alm_wait        <= 1'b0;
         RTC_IRQ_OE_N_O  <= 1'b1;
      end else begin
         periodic_flag   <= per_ev | (periodic_flag & ~clr_c);
         update_end_flag <= upd | (update_end_flag & ~clr_c);
         // compare one reference tick after the update ends
         if (upd)
            alm_wait <= 1'b1;
         else if (ref_tick)
            alm_wait <= 1'b0;
         alarm_flag     <= (alm_wait & ref_tick & ~upd & alm_hit) | (alarm_flag & ~clr_c);
         RTC_IRQ_OE_N_O <= ~irq_flag_any;
      end
   end
   assign irq_flag_any = (periodic_flag & control_reg_b[`RTC_CRB_PIE])
                       | (alarm_flag & control_reg_b[`RTC_CRB_AIE])
                       | (update_end_flag & control_reg_b[`RTC_CRB_UIE]);
   // open-drain: only ever drives low
   assign RTC_IRQ_O = 1'b0;

   // alarm registers
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 7; i = i + 1)
            alm[i] <= 8'h00;
      end else if (wr && is_alm) begin
         alm[slot] <= wdat;
      end
   end

   // user copies: snapshot on freeze, host writes while frozen
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 7; i = i + 1)
            usr[i] <= 8'h00;
         load_pend <= 1'b0;
      end else begin
         if (wr && ix == `RTC_IX_CRB && wdat[`RTC_CRB_SET] && !frozen) begin
            for (i = 0; i < 7; i = i + 1)
               usr[i] <= cur[i];
         end else if (wr && is_time && frozen) begin
            usr[slot] <= wdat;
         end
         if (wr && ix == `RTC_IX_CRB && !wdat[`RTC_CRB_SET] && frozen)
            load_pend <= 1'b1;
         else if (!upd)
            load_pend <= 1'b0;
      end
   end

   // running counters advance every second whatever freeze says
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 7; i = i + 1)
            cur[i] <= 8'h00;
         cur[3] <= 8'h01;
         cur[4] <= 8'h01;
         cur[5] <= 8'h01;
      end else if (upd) begin
         cur[0] <= nx_w[0];
         if (wrap_w[0])
            cur[1] <= nx_w[1];
         if (wrap_w[0] & wrap_w[1])
            cur[2] <= h24 ? nx_w[2] : {cur[2][7] ^ (nx_w[2] == (bcd ? 8'h12 : 8'h0c)), nx_w[2][6:0]};
         if (wrap_w[0] & wrap_w[1] & hr_day) begin
            cur[3] <= nx_w[3];
            cur[4] <= nx_w[4];
            if (wrap_w[4])
               cur[5] <= nx_w[5];
            if (wrap_w[4] & wrap_w[5])
               cur[6] <= nx_w[6];
         end
      end else if (load_pend) begin
         // the update pulse is one cycle, so a load that meets it runs one cycle later
         for (i = 0; i < 7; i = i + 1)
            cur[i] <= usr[i];
      end else if (wr && is_time && !frozen) begin
         cur[slot] <= wdat;
      end
   end
endmodule // rtc_core

/* File: dv/rtc_core_props.sv */
// rtc_core_props.sv: bus and interrupt pin checks for the rtc core.
// assumes a master that holds each request until waitrequest is low.
`timescale 1ns/10ps
`include "rtc_map.vh"
module rtc_core_props #(
   parameter LOCK_CYC = 50
) (
   input wire        CLK_SYS_I,
   input wire        RST_N_I,
   input wire        SLOW_CLK_I,
   input wire        VCC_OK_I,
   input wire [6:0]  AVS_ADDRESS_I,
   input wire        AVS_READ_I,
   input wire        AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0]  AVS_BYTEENABLE_I,
   input wire [31:0] AVS_READDATA_O,
   input wire        AVS_WAITREQUEST_O,
   input wire        RTC_IRQ_O,
   input wire        RTC_IRQ_OE_N_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   // request and location seen by the slave
   wire       req = AVS_READ_I | AVS_WRITE_I;
   wire [4:0] ix  = AVS_ADDRESS_I[6:2];

   chk_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
      else $error("new request answered without a wait cycle");
   chk_wait_once: assert property (AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("more than one wait cycle");
   chk_wait_idle: assert property (!req |-> !AVS_WAITREQUEST_O)
      else $error("waitrequest without a request");
   chk_pin_value: assert property (RTC_IRQ_O == 1'b0)
      else $error("interrupt pin drives a high level");
   chk_rdata_upper: assert property (AVS_READDATA_O[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   chk_rdata_hold: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
      else $error("read data changed without a read");
   chk_lock_read: assert property ((AVS_READ_I && AVS_WAITREQUEST_O && !VCC_OK_I && !$past(VCC_OK_I))
      |=> AVS_READDATA_O == 32'h0)
      else $error("read under low supply returned data");
   chk_unmapped_zero: assert property ((AVS_READ_I && AVS_WAITREQUEST_O && ix > `RTC_IX_ALM_YEAR)
      |=> AVS_READDATA_O == 32'h0)
      else $error("unmapped read returned data");
   chk_regd_const: assert property ((AVS_READ_I && AVS_WAITREQUEST_O && ix == `RTC_IX_CRD)
      |=> AVS_READDATA_O inside {`RTC_CRD_VAL, 32'h0})
      else $error("register d read wrong");
endmodule // rtc_core_props

bind rtc_core rtc_core_props #(.LOCK_CYC(LOCK_CYC)) i_props (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .SLOW_CLK_I(SLOW_CLK_I), .VCC_OK_I(VCC_OK_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
   .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .RTC_IRQ_O(RTC_IRQ_O),
   .RTC_IRQ_OE_N_O(RTC_IRQ_OE_N_O));

/* File: dv/rtc_ref_model.sv */
// rtc_ref_model.sv: reference tick source and pulled-up interrupt wire.
// assumes the core samples the reference on the system clock.
`timescale 1ns/10ps
module rtc_ref_model (
   input  wire clk_i,
   input  wire run_i,
   input  wire irq_i,
   input  wire irq_oe_n_i,
   output reg  slow_clk_o,
   output wire irq_line_o
);
   // reference sped up to one tick per two cycles, else a second lasts too long
   initial slow_clk_o = 1'b0;
   always @(posedge clk_i) begin
      slow_clk_o <= run_i ? ~slow_clk_o : 1'b0;
   end
   // open drain with external pull-up
   assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_i;
endmodule // rtc_ref_model

/* File: dv/rtc_timekeeping_alarm_core_tb_top.sv */
// rtc_timekeeping_alarm_core_tb_top.sv: self-checking bench of the rtc core.
// assumes the reference model ticks every two system cycles.
`timescale 1ns/10ps
`include "rtc_map.vh"
module rtc_timekeeping_alarm_core_tb_top;
   localparam LOCK = 50;
   reg         clk    = 1'b0;
   reg         rst_n  = 1'b0;
   reg         vcc_ok = 1'b1;
   reg  [6:0]  addr   = 7'h00;
   reg         rd_en  = 1'b0;
   reg         wr_en  = 1'b0;
   reg  [31:0] wdata  = 32'h0;
   reg  [3:0]  be     = 4'h0;
   wire [31:0] rdata;
   wire        waitreq;
   wire        irq_o;
   wire        irq_oe_n;
   wire        slow_clk;
   wire        irq_line;
   integer     n_mismatch = 0;
   integer     samples_checked = 0;
   integer     cyc = 0;
   reg  [7:0]  rd;

   // 200 mhz system clock
   initial forever #2.5 clk = ~clk;

   rtc_core #(.LOCK_CYC(LOCK)) i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .SLOW_CLK_I(slow_clk), .VCC_OK_I(vcc_ok),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .RTC_IRQ_O(irq_o),
      .RTC_IRQ_OE_N_O(irq_oe_n));
   rtc_ref_model i_ref (.clk_i(clk), .run_i(rst_n), .irq_i(irq_o), .irq_oe_n_i(irq_oe_n),
      .slow_clk_o(slow_clk), .irq_line_o(irq_line));

   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
         end
      end
   endtask
   // one avalon access; held until waitrequest is sampled low
   task bus(input wr, input [4:0] ix, input [7:0] d, input [3:0] b);
      integer k;
      begin
         @(posedge clk);
         addr <= {ix, 2'b00};
         rd_en <= ~wr;
         wr_en <= wr;
         wdata <= {24'h0, d};
         be <= b;
         k = 0;
         @(posedge clk);
         while (waitreq !== 1'b0 && k < 20) begin
            @(posedge clk);
            k = k + 1;
         end
         chk(k < 20, 1);
         rd = rdata[7:0];
         rd_en <= 1'b0;
         wr_en <= 1'b0;
      end
   endtask
   task wr(input [4:0] ix, input [7:0] d);
      bus(1'b1, ix, d, 4'hf);
   endtask
   task rdchk(input [4:0] ix, input [7:0] exp);
      begin
         bus(1'b0, ix, 8'h00, 4'hf);
         chk(rd, exp);
      end
   endtask
   // fields in order sec, min, hour, dow, date, month, year
   task set_time(input [55:0] v);
      integer j;
      for (j = 0; j < 7; j = j + 1) wr(5'((j < 3) ? 2 * j : j + 3), v[55 - 8 * j -: 8]);
   endtask
   task chk_time(input [55:0] v);
      integer j;
      for (j = 0; j < 7; j = j + 1) rdchk(5'((j < 3) ? 2 * j : j + 3), v[55 - 8 * j -: 8]);
   endtask
   task wait_irq(input integer lim);
      integer k;
      begin
         k = 0;
         while (irq_line !== 1'b0 && k < lim) begin
            @(posedge clk);
            k = k + 1;
         end
         chk(k < lim, 1);
      end
   endtask

   task t_regs;
      begin
         rdchk(`RTC_IX_CRA, `RTC_CRA_RST);
         rdchk(`RTC_IX_CRB, `RTC_CRB_RST);
         rdchk(`RTC_IX_CRC, 8'h00);
         rdchk(`RTC_IX_CRD, `RTC_CRD_VAL);
         rdchk(5'h1f, 8'h00);
         wr(`RTC_IX_CRA, 8'ha0);
         rdchk(`RTC_IX_CRA, 8'h20);
         wr(`RTC_IX_CRD, 8'h00);
         rdchk(`RTC_IX_CRD, `RTC_CRD_VAL);
         bus(1'b1, `RTC_IX_SEC, 8'h33, 4'he);
         chk_time(56'h00_00_00_01_01_01_00);
         $display("t_regs done");
      end
   endtask
   // freeze, load end of year, all alarms dont care, then wait the update
   task t_freeze;
      integer i;
      integer k;
      begin
         wr(`RTC_IX_CRB, 8'h82);
         set_time(56'h59_59_23_07_31_12_99);
         rdchk(`RTC_IX_SEC, 8'h59);
         for (i = 0; i < 7; i = i + 1) wr(5'((i < 3) ? 2 * i + 1 : i + 11), 8'hc0);
         wr(`RTC_IX_CRB, 8'h32);
         k = 0;
         rd = 8'h00;
         while (rd[`RTC_CRA_UIP] !== 1'b1 && k < 15000) begin
            bus(1'b0, `RTC_IX_CRA, 8'h00, 4'hf);
            k = k + 1;
         end
         chk(k < 15000, 1);
         wait_irq(40);
         repeat (8) @(posedge clk);
         rdchk(`RTC_IX_CRC, 8'hb0);
         rdchk(`RTC_IX_CRC, 8'h00);
         repeat (3) @(posedge clk);
         chk(irq_line, 1);
         chk_time(56'h00_00_00_01_01_01_00);
         $display("t_freeze done");
      end
   endtask
   // divider held, binary leap day, then restart and wait half a second
   task t_leap;
      begin
         // held with a fast rate: a running chain would flag periodic here
         wr(`RTC_IX_CRA, 8'h63);
         repeat (40) @(posedge clk);
         rdchk(`RTC_IX_CRC, 8'h00);
         wr(`RTC_IX_CRB, 8'h16);
         set_time(56'h3b_3b_17_03_1c_02_04);
         // a cared seconds field that misses keeps alarm_flag clear
         wr(`RTC_IX_ALM_SEC, 8'h01);
         wr(`RTC_IX_CRA, 8'h20);
         wait_irq(33500);
         chk_time(56'h00_00_00_04_1d_02_04);
         rdchk(`RTC_IX_CRC, 8'h90);
         $display("t_leap done");
      end
   endtask
   task t_periodic;
      begin
         wr(`RTC_IX_CRA, 8'h23);
         wr(`RTC_IX_CRB, 8'h42);
         wait_irq(200);
         rdchk(`RTC_IX_CRC, 8'hc0);
         wr(`RTC_IX_CRA, 8'h20);
         bus(1'b0, `RTC_IX_CRC, 8'h00, 4'hf);
         repeat (40) @(posedge clk);
         chk(irq_line, 1);
         $display("t_periodic done");
      end
   endtask
   // writes and reads refused while the supply is low
   task t_lockout;
      begin
         vcc_ok <= 1'b0;
         repeat (3) @(posedge clk);
         wr(`RTC_IX_SEC, 8'h11);
         rdchk(`RTC_IX_CRD, 8'h00);
         vcc_ok <= 1'b1;
         repeat (LOCK + 10) @(posedge clk);
         rdchk(`RTC_IX_SEC, 8'h00);
         $display("t_lockout done");
      end
   endtask

   task finish_test;
      begin
         $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // cycle ceiling a little above the two half-second waits
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_regs;
      t_freeze;
      t_leap;
      t_periodic;
      t_lockout;
      finish_test;
   end
endmodule // rtc_timekeeping_alarm_core_tb_top
